// *** rtl/cise_alu.v ***
// Single-operand and compare arithmetic with flag generation.
`timescale 1ns/1ps
`include "cise_consts.vh"
module cise_alu (
	// Operation select: 0 clear, 1 complement, 2 decrement, 3 increment, 4 compare.
	input wire [2:0] op,
	input wire [7:0] dst,
	input wire [7:0] src,
	input wire [7:0] flagsIn,
	// Results.
	output reg [7:0] result,
	output reg [7:0] flagsOut
);
	// Wide difference for the borrow out of compare.
	wire [8:0] diff = {1'b0, dst} - {1'b0, src};

	// ------------------------------------------------------------------------
	// Result and flags per operation.
	// ------------------------------------------------------------------------
	always @* begin
		result = 8'h00;
		flagsOut = flagsIn;
		case (op)
			3'h0: begin
				result = 8'h00;
			end
			3'h1: begin
				result = ~dst;
				flagsOut[`CISE_FLAG_Z] = (result == 8'h00);
				flagsOut[`CISE_FLAG_S] = result[7];
				flagsOut[`CISE_FLAG_V] = 1'b0;
			end
			3'h2: begin
				result = dst - 8'h01;
				flagsOut[`CISE_FLAG_Z] = (result == 8'h00);
				flagsOut[`CISE_FLAG_S] = result[7];
				flagsOut[`CISE_FLAG_V] = (dst == `CISE_OVF_NEG);
			end
			3'h3: begin
				result = dst + 8'h01;
				flagsOut[`CISE_FLAG_Z] = (result == 8'h00);
				flagsOut[`CISE_FLAG_S] = result[7];
				flagsOut[`CISE_FLAG_V] = (dst == `CISE_OVF_POS);
			end
			3'h4: begin
				result = diff[7:0];
				flagsOut[`CISE_FLAG_C] = diff[8];
				flagsOut[`CISE_FLAG_Z] = (diff[7:0] == 8'h00);
				flagsOut[`CISE_FLAG_S] = diff[7];
				flagsOut[`CISE_FLAG_V] = (dst[7] ^ src[7]) & (diff[7] == src[7]);
			end
			default: begin
				result = 8'h00;
			end
		endcase
	end
endmodule // cise_alu

// *** rtl/cise_cond_eval.v ***
// Condition-code evaluator for conditional branches.
`timescale 1ns/1ps
`include "cise_consts.vh"
module cise_cond_eval (
	// Condition and flags.
	input wire [3:0] cond,
	input wire [7:0] flags,
	// Verdict.
	output reg taken
);
	// Individual flag bits.
	wire c = flags[`CISE_FLAG_C];
	wire z = flags[`CISE_FLAG_Z];
	wire s = flags[`CISE_FLAG_S];
	wire v = flags[`CISE_FLAG_V];

	// ------------------------------------------------------------------------
	// Evaluation: the upper eight codes are the negations of the lower eight.
	// ------------------------------------------------------------------------
	reg base;
	always @* begin
		case (cond[2:0])
			3'h0: base = 1'b0; // Never, negated gives always.
			3'h1: base = s ^ v; // Signed less than.
			3'h2: base = z | (s ^ v); // Signed less or equal.
			3'h3: base = c | z; // Unsigned less or equal.
			3'h4: base = v; // Overflow.
			3'h5: base = s; // Minus.
			3'h6: base = z; // Equal.
			3'h7: base = c; // Carry.
			default: base = 1'b0;
		endcase
		taken = cond[3] ? ~base : base;
	end
endmodule // cise_cond_eval

// *** rtl/cise_consts.vh ***
// Constants for the instruction subset executor.
`ifndef CISE_CONSTS_VH
`define CISE_CONSTS_VH
// ----------------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------------
`define CISE_OP_CLR_R 8'hb0
`define CISE_OP_CLR_IR 8'hb1
`define CISE_OP_COM_R 8'h60
`define CISE_OP_COM_IR 8'h61
`define CISE_OP_CMP_RR 8'ha2
`define CISE_OP_CMP_RIR 8'ha3
`define CISE_OP_CMP_RR3 8'ha4
`define CISE_OP_CMP_RIR3 8'ha5
`define CISE_OP_CMP_RIM 8'ha6
`define CISE_OP_DEC_R 8'h00
`define CISE_OP_DEC_IR 8'h01
`define CISE_OP_INC_R 8'h20
`define CISE_OP_INC_IR 8'h21
`define CISE_OP_DI 8'h8f
`define CISE_OP_EI 8'h9f
`define CISE_OP_IDLE 8'h6f
`define CISE_OP_SERVICE_RETURN_INSTR 8'hbf
`define CISE_OP_JP_IRR 8'h30
`define CISE_OP_LD_RIR 8'hc7
// Low-nibble opcodes with a register or condition in the upper nibble.
`define CISE_NIB_INC 4'he
`define CISE_NIB_JP 4'hd
`define CISE_NIB_JR 4'hb
`define CISE_NIB_LDIM 4'hc
`define CISE_NIB_LDR 4'h8
`define CISE_NIB_STR 4'h9
// ----------------------------------------------------------------------------
// Register file and flags
// ----------------------------------------------------------------------------
`define CISE_WREG_BASE 4'hc
`define CISE_SYM_IE_BIT 3
`define CISE_FLAG_C 7
`define CISE_FLAG_Z 6
`define CISE_FLAG_S 5
`define CISE_FLAG_V 4
`define CISE_SYM_RESET 8'h00
`define CISE_FLAGS_RESET 8'h00
`define CISE_PC_RESET 16'h0000
`define CISE_SP_RESET 8'h00
`define CISE_INT_VECTOR 16'h0000
`define CISE_OVF_NEG 8'h80
`define CISE_OVF_POS 8'h7f
// ----------------------------------------------------------------------------
// Cycle counts
// ----------------------------------------------------------------------------
`define CISE_CYC_4 4'h4
`define CISE_CYC_6 4'h6
`define CISE_CYC_8 4'h8
`define CISE_CYC_10 4'ha
`endif

// *** rtl/cise_core.v ***
// Fetch, decode and execute of the instruction subset with its own register file.
`timescale 1ns/1ps
`include "cise_consts.vh"
module cise_core (
	// Clock and reset.
	input wire clk,
	input wire rst_n,
	// Program memory read port, asynchronous data.
	output wire [15:0] progAddr,
	input wire [7:0] progData,
	// Interrupt request lines.
	input wire [7:0] irqIn,
	// Status.
	output reg [7:0] systemModeReg_q,
	output reg [7:0] flags_q,
	output reg [7:0] pending_q,
	output reg [15:0] pc_q,
	output reg [7:0] sp_q,
	output reg idle_q,
	output reg busy_q,
	output reg illegal_q
);
	// ------------------------------------------------------------------------
	// State machine codes.
	// ------------------------------------------------------------------------
	localparam S_FETCH = 3'h0;
	localparam S_OP1 = 3'h1;
	localparam S_OP2 = 3'h2;
	localparam S_EXEC = 3'h3;
	localparam S_WAIT = 3'h4;
	localparam S_IDLE = 3'h5;

	// Register file, which also holds the stack.
	reg [7:0] regFile [0:255];
	// Current state and instruction bytes.
	reg [2:0] state_q;
	reg [7:0] opc_q;
	reg [7:0] b1_q;
	reg [7:0] b2_q;
	// Cycles elapsed so far in the current instruction.
	reg [3:0] cyc_q;
	// Number of operand bytes after the opcode.
	reg [1:0] need_q;

	assign progAddr = pc_q;

	// ------------------------------------------------------------------------
	// Decode helpers.
	// ------------------------------------------------------------------------
	wire [3:0] hiN = opc_q[7:4];
	wire [3:0] loN = opc_q[3:0];
	// Working register address from a nibble.
	function [7:0] wreg;
		input [3:0] n;
		begin
			wreg = {`CISE_WREG_BASE, n};
		end
	endfunction

	// Byte count from the first opcode byte.
	function [1:0] extraBytes;
		input [7:0] op;
		begin
			case (op[3:0])
				`CISE_NIB_INC: extraBytes = 2'h0;
				`CISE_NIB_JP: extraBytes = 2'h2;
				`CISE_NIB_JR, `CISE_NIB_LDIM, `CISE_NIB_LDR, `CISE_NIB_STR: extraBytes = 2'h1;
				default: begin
					if (op == `CISE_OP_DI || op == `CISE_OP_EI || op == `CISE_OP_IDLE ||
							op == `CISE_OP_SERVICE_RETURN_INSTR)
						extraBytes = 2'h0;
					else if (op == `CISE_OP_CMP_RR3 || op == `CISE_OP_CMP_RIR3 ||
							op == `CISE_OP_CMP_RIM)
						extraBytes = 2'h2;
					else
						extraBytes = 2'h1;
				end
			endcase
		end
	endfunction

	// Condition verdict for branch opcodes.
	wire condTaken;
	cise_cond_eval uCond (
		.cond(hiN),
		.flags(flags_q),
		.taken(condTaken)
	);

	// ------------------------------------------------------------------------
	// Operand selection for the arithmetic unit.
	// ------------------------------------------------------------------------
	reg [2:0] aluOp;
	reg [7:0] dstAddr;
	reg [7:0] srcVal;
	reg doWrite;
	reg doFlags;
	reg isLegal;
	reg [3:0] cycles;
	always @* begin
		aluOp = 3'h0;
		dstAddr = b1_q;
		srcVal = 8'h00;
		doWrite = 1'b0;
		doFlags = 1'b0;
		isLegal = 1'b1;
		cycles = `CISE_CYC_4;
		case (opc_q)
			`CISE_OP_CLR_R: begin
				doWrite = 1'b1;
			end
			`CISE_OP_CLR_IR: begin
				dstAddr = regFile[b1_q];
				doWrite = 1'b1;
			end
			`CISE_OP_COM_R, `CISE_OP_COM_IR: begin
				aluOp = 3'h1;
				if (opc_q == `CISE_OP_COM_IR)
					dstAddr = regFile[b1_q];
				doWrite = 1'b1;
				doFlags = 1'b1;
			end
			`CISE_OP_DEC_R, `CISE_OP_DEC_IR: begin
				aluOp = 3'h2;
				if (opc_q == `CISE_OP_DEC_IR)
					dstAddr = regFile[b1_q];
				doWrite = 1'b1;
				doFlags = 1'b1;
			end
			`CISE_OP_INC_R, `CISE_OP_INC_IR: begin
				aluOp = 3'h3;
				if (opc_q == `CISE_OP_INC_IR)
					dstAddr = regFile[b1_q];
				doWrite = 1'b1;
				doFlags = 1'b1;
			end
			`CISE_OP_CMP_RR, `CISE_OP_CMP_RIR: begin
				aluOp = 3'h4;
				dstAddr = wreg(b1_q[7:4]);
				srcVal = (opc_q == `CISE_OP_CMP_RR) ? regFile[wreg(b1_q[3:0])] :
					regFile[regFile[wreg(b1_q[3:0])]];
				doFlags = 1'b1;
				cycles = (opc_q == `CISE_OP_CMP_RR) ? `CISE_CYC_4 : `CISE_CYC_6;
			end
			`CISE_OP_CMP_RR3, `CISE_OP_CMP_RIR3, `CISE_OP_CMP_RIM: begin
				aluOp = 3'h4;
				cycles = `CISE_CYC_6;
				doFlags = 1'b1;
				if (opc_q == `CISE_OP_CMP_RIM) begin
					dstAddr = b1_q;
					srcVal = b2_q;
				end else begin
					dstAddr = b2_q;
					srcVal = (opc_q == `CISE_OP_CMP_RR3) ? regFile[b1_q] : regFile[regFile[b1_q]];
				end
			end
			`CISE_OP_DI, `CISE_OP_EI, `CISE_OP_IDLE: begin
				cycles = `CISE_CYC_4;
			end
			`CISE_OP_SERVICE_RETURN_INSTR: begin
				cycles = `CISE_CYC_10;
			end
			`CISE_OP_JP_IRR: begin
				cycles = `CISE_CYC_8;
			end
			`CISE_OP_LD_RIR: begin
				dstAddr = wreg(b1_q[7:4]);
				srcVal = regFile[regFile[wreg(b1_q[3:0])]];
			end
			default: begin
				case (loN)
					`CISE_NIB_INC: begin
						aluOp = 3'h3;
						dstAddr = wreg(hiN);
						doWrite = 1'b1;
						doFlags = 1'b1;
					end
					`CISE_NIB_JP: cycles = `CISE_CYC_8;
					`CISE_NIB_JR: cycles = `CISE_CYC_6;
					`CISE_NIB_LDIM: begin
						dstAddr = wreg(hiN);
						srcVal = b1_q;
					end
					`CISE_NIB_LDR: begin
						dstAddr = wreg(hiN);
						srcVal = regFile[b1_q];
					end
					`CISE_NIB_STR: begin
						dstAddr = b1_q;
						srcVal = regFile[wreg(hiN)];
					end
					default: isLegal = 1'b0;
				endcase
			end
		endcase
	end

	// Arithmetic unit on the selected destination.
	wire [7:0] aluResult;
	wire [7:0] aluFlags;
	cise_alu uAlu (
		.op(aluOp),
		.dst(regFile[dstAddr]),
		.src(srcVal),
		.flagsIn(flags_q),
		.result(aluResult),
		.flagsOut(aluFlags)
	);

	// Plain moves write the source value, arithmetic writes the result.
	wire isMove = (opc_q == `CISE_OP_LD_RIR) || ((loN == `CISE_NIB_LDIM ||
		loN == `CISE_NIB_LDR || loN == `CISE_NIB_STR) && opc_q != `CISE_OP_DI &&
		opc_q != `CISE_OP_EI);
	// Sign-extended displacement and next-instruction address.
	wire [15:0] relTarget = pc_q + {{8{b1_q[7]}}, b1_q};
	// Any pending request while interrupts are enabled.
	wire irqTake = systemModeReg_q[`CISE_SYM_IE_BIT] && (pending_q != 8'h00);

	// ------------------------------------------------------------------------
	// Register file writes: one port, taken at the end of the execute state or on an interrupt push.
	// ------------------------------------------------------------------------
	always @(posedge clk) begin
		if (state_q == S_EXEC && isLegal && (doWrite || isMove))
			regFile[dstAddr] <= isMove ? srcVal : aluResult;
		else if (state_q == S_FETCH && irqTake && !busy_q) begin
			regFile[sp_q - 8'h01] <= pc_q[7:0];
		end
	end

	// ------------------------------------------------------------------------
	// Pending latch: set wins over the clear of the one being serviced.
	// ------------------------------------------------------------------------
	reg [7:0] svcMask;
	integer i;
	always @* begin
		svcMask = 8'h00;
		for (i = 7; i >= 0; i = i - 1) begin
			if (pending_q[i])
				svcMask = 8'h01 << i;
		end
	end

	// ------------------------------------------------------------------------
	// Sequencer.
	// ------------------------------------------------------------------------
	always @(posedge clk) begin
		if (!rst_n) begin
			state_q <= S_FETCH;
			pc_q <= `CISE_PC_RESET;
			sp_q <= `CISE_SP_RESET;
			flags_q <= `CISE_FLAGS_RESET;
			systemModeReg_q <= `CISE_SYM_RESET;
			pending_q <= 8'h00;
			opc_q <= 8'h00;
			b1_q <= 8'h00;
			b2_q <= 8'h00;
			cyc_q <= 4'h0;
			need_q <= 2'h0;
			idle_q <= 1'b0;
			busy_q <= 1'b0;
			illegal_q <= 1'b0;
		end else begin
			// Requests always latch, whether enabled or not.
			if (state_q == S_FETCH && irqTake)
				pending_q <= (pending_q & ~svcMask) | irqIn;
			else
				pending_q <= pending_q | irqIn;
			case (state_q)
				S_FETCH: begin
					if (irqTake) begin
						// Vector: push PC low only, keep it compact, and mask.
						sp_q <= sp_q - 8'h01;
						pc_q <= `CISE_INT_VECTOR;
						systemModeReg_q[`CISE_SYM_IE_BIT] <= 1'b0;
						busy_q <= 1'b0;
					end else begin
						opc_q <= progData;
						pc_q <= pc_q + 16'h0001;
						need_q <= extraBytes(progData);
						cyc_q <= 4'h1;
						busy_q <= 1'b1;
						state_q <= (extraBytes(progData) == 2'h0) ? S_EXEC : S_OP1;
					end
				end
				S_OP1: begin
					b1_q <= progData;
					pc_q <= pc_q + 16'h0001;
					cyc_q <= cyc_q + 4'h1;
					state_q <= (need_q == 2'h2) ? S_OP2 : S_EXEC;
				end
				S_OP2: begin
					b2_q <= progData;
					pc_q <= pc_q + 16'h0001;
					cyc_q <= cyc_q + 4'h1;
					state_q <= S_EXEC;
				end
				S_EXEC: begin
					illegal_q <= ~isLegal;
					if (doFlags)
						flags_q <= aluFlags;
					if (opc_q == `CISE_OP_DI)
						systemModeReg_q[`CISE_SYM_IE_BIT] <= 1'b0;
					if (opc_q == `CISE_OP_EI)
						systemModeReg_q[`CISE_SYM_IE_BIT] <= 1'b1;
					if (opc_q == `CISE_OP_SERVICE_RETURN_INSTR) begin
						flags_q <= regFile[sp_q];
						pc_q <= {regFile[sp_q + 8'h01], regFile[sp_q + 8'h02]};
						sp_q <= sp_q + 8'h03;
						systemModeReg_q[`CISE_SYM_IE_BIT] <= 1'b1;
					end
					if (opc_q == `CISE_OP_JP_IRR)
						pc_q <= {regFile[b1_q], regFile[b1_q + 8'h01]};
					if (loN == `CISE_NIB_JP && opc_q != `CISE_OP_DI && condTaken)
						pc_q <= {b1_q, b2_q};
					if (loN == `CISE_NIB_JR && opc_q != `CISE_OP_SERVICE_RETURN_INSTR && condTaken)
						pc_q <= relTarget;
					cyc_q <= cyc_q + 4'h1;
					state_q <= S_WAIT;
				end
				S_WAIT: begin
					// This edge closes the instruction once it is its last cycle.
					if ((cyc_q + 4'h1) >= cycles) begin
						busy_q <= 1'b0;
						if (opc_q == `CISE_OP_IDLE) begin
							idle_q <= 1'b1;
							state_q <= S_IDLE;
						end else begin
							state_q <= S_FETCH;
						end
					end else begin
						cyc_q <= cyc_q + 4'h1;
					end
				end
				S_IDLE: begin
					// Execution halted; any request wakes the core.
					if ((pending_q | irqIn) != 8'h00) begin
						idle_q <= 1'b0;
						state_q <= S_FETCH;
					end
				end
				default: state_q <= S_FETCH;
			endcase
		end
	end
endmodule // cise_core

// *** verification/cise_core_asserts.sv ***
// Concurrent checks on the ports of the instruction subset executor.
`timescale 1ns/1ps
module cise_core_asserts (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Watched ports.
	input wire logic [15:0] progAddr,
	input wire logic [7:0] irqIn,
	input wire logic [7:0] systemModeReg_q,
	input wire logic [7:0] flags_q,
	input wire logic [7:0] pending_q,
	input wire logic [15:0] pc_q,
	input wire logic [7:0] sp_q,
	input wire logic idle_q
);
	// ------------------------------------------------------------
	// Reset and fetch address
	// ------------------------------------------------------------
	// A reset edge leaves the status outputs cleared.
	a_reset_clears: assert property (@(posedge clk) !rst_n |=> (pc_q == 16'h0000
		&& flags_q == 8'h00 && systemModeReg_q == 8'h00 && sp_q == 8'h00 && !idle_q))
		else $error("status not cleared by reset");
	// The fetch address always follows the program counter.
	a_addr_follows_pc: assert property (@(posedge clk) disable iff (!rst_n) progAddr == pc_q)
		else $error("fetch address differs from program counter");
	// ------------------------------------------------------------
	// Interrupt enable, pending and idle
	// ------------------------------------------------------------
	// Requests are latched while global processing is off.
	a_pend_latch: assert property (@(posedge clk) disable iff (!rst_n)
		(irqIn != 8'h00 && !systemModeReg_q[3]) |=> ((pending_q & $past(irqIn)) == $past(irqIn)))
		else $error("request not latched into pending");
	// Idle with nothing pending freezes the program counter and flags.
	a_idle_holds: assert property (@(posedge clk) disable iff (!rst_n)
		(idle_q && pending_q == 8'h00 && irqIn == 8'h00) |=> ($stable(pc_q) && $stable(flags_q)))
		else $error("core advanced while idle");
	// A pending request ends idle within a few cycles.
	a_idle_wakes: assert property (@(posedge clk) disable iff (!rst_n)
		(idle_q && (pending_q | irqIn) != 8'h00) |-> ##[1:8] !idle_q)
		else $error("idle not released by request");
	// With processing on, a pending request reaches the vector.
	a_pend_serviced: assert property (@(posedge clk) disable iff (!rst_n)
		(systemModeReg_q[3] && pending_q != 8'h00 && !idle_q) |-> ##[1:24] (pc_q == 16'h0000))
		else $error("pending request not serviced");
	// Enabling touches only the enable bit.
	a_enable_bit_only: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(systemModeReg_q[3]) |-> ($stable(systemModeReg_q[7:4])
		&& $stable(systemModeReg_q[2:0])))
		else $error("enable changed other mode bits");
	// Disabling touches only the enable bit and leaves the flags.
	a_disable_bit_only: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(systemModeReg_q[3]) |-> ($stable(systemModeReg_q[7:4])
		&& $stable(systemModeReg_q[2:0]) && $stable(flags_q)))
		else $error("disable changed other bits");
endmodule // cise_core_asserts

bind cise_core cise_core_asserts cise_core_asserts_i (.clk(clk), .rst_n(rst_n),
	.progAddr(progAddr), .irqIn(irqIn), .systemModeReg_q(systemModeReg_q), .flags_q(flags_q),
	.pending_q(pending_q), .pc_q(pc_q), .sp_q(sp_q), .idle_q(idle_q));

// *** verification/cise_prog_mem.sv ***
// Program memory model that answers every fetch in the same cycle.
`timescale 1ns/1ps
module cise_prog_mem (
	// Fetch address.
	input wire logic [15:0] addr,
	// Fetched byte.
	output logic [7:0] data
);
	// Low page of program bytes, loaded by the bench between runs.
	logic [7:0] mem [0:255];
	// Above the low page the idle opcode is read, so a stray jump parks the core.
	assign data = (addr[15:8] == 8'h00) ? mem[addr[7:0]] : 8'h6f;
endmodule // cise_prog_mem

// *** verification/tb.sv ***
// Self-checking bench for the instruction subset executor.
`timescale 1ns/1ps
module tb;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic clk;
	logic rst_n;
	logic [15:0] progAddr;
	logic [7:0] progData;
	logic [7:0] irqIn;
	logic [7:0] systemModeReg_q;
	logic [7:0] flags_q;
	logic [7:0] pending_q;
	logic [15:0] pc_q;
	logic [7:0] sp_q;
	logic idle_q;
	logic busy_q;
	logic illegal_q;
	// Bench bookkeeping and test tables.
	integer n_fail;
	integer check_count;
	integer n_test;
	integer cyc;
	integer c1;
	integer k;
	logic hit;
	logic e;
	logic [127:0] tp [0:12];
	logic [7:0] te [0:12];
	integer tn [0:12];
	logic [63:0] dp [0:3];
	integer dn [0:3];
	integer dc [0:3];
	cise_core cise_core_i (.clk(clk), .rst_n(rst_n), .progAddr(progAddr), .progData(progData),
		.irqIn(irqIn), .systemModeReg_q(systemModeReg_q), .flags_q(flags_q),
		.pending_q(pending_q), .pc_q(pc_q), .sp_q(sp_q), .idle_q(idle_q), .busy_q(busy_q),
		.illegal_q(illegal_q));
	cise_prog_mem cise_prog_mem_i (.addr(progAddr), .data(progData));
	// Free-running 100 MHz clock.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	// Compares a value and counts the result.
	task chkv(input [15:0] got, input [15:0] exp, input string msg);
		check_count = check_count + 1;
		if (got !== exp) begin
			n_fail = n_fail + 1;
			$display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask
	// Compares a single bit and counts the result.
	task chkb(input logic got, input logic exp, input string msg);
		check_count = check_count + 1;
		if (got !== exp) begin
			n_fail = n_fail + 1;
			$display("mismatch at %0t: %s got %b expected %b", $time, msg, got, exp);
		end
	endtask
	// Prints the counts and the verdict, then ends the run.
	task results;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Loads a program with a self-loop at stop, resets, and runs until stop is reached or lim cycles pass, then 16 more.
	// Unused memory holds the idle opcode, so a wrong path parks instead of running on.
	task run(input [127:0] b, input integer n, input [15:0] stop, input integer lim);
		integer i;
		for (i = 0; i < 256; i = i + 1) cise_prog_mem_i.mem[i] = 8'h6f;
		for (i = 0; i < n; i = i + 1) cise_prog_mem_i.mem[i] = b[8 * (n - 1 - i) +: 8];
		cise_prog_mem_i.mem[stop[7:0]] = 8'h8b;
		cise_prog_mem_i.mem[stop[7:0] + 8'h01] = 8'hfe;
		rst_n = 1'b0;
		repeat (5) @(posedge clk);
		#1 rst_n = 1'b1;
		hit = 1'b0;
		cyc = 0;
		while (!hit && cyc < lim) begin
			@(posedge clk);
			#1 cyc = cyc + 1;
			if (pc_q === stop) hit = 1'b1;
		end
		repeat (16) @(posedge clk);
		#1 n_test = n_test + 1;
		$display("test %0d done", n_test);
	endtask
	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		irqIn = 8'h00;
		n_fail = 0;
		check_count = 0;
		n_test = 0;
		tp = '{128'h1c7f1e, 128'h1c8000c1, 128'h1c022c03a2123cff60c3, 128'h1c802c01a212,
			128'h1c802c01a212a6c180, 128'h1c55b0c1a6c100, 128'h1cc22c33b1c1a6c200,
			128'h1cc22c5ac731a6c35a, 128'h1c7719202820a6c277,
			128'h1cc22c7e21c101c120c261c1, 128'h1cc22c05a4c1c2, 128'h1cc22c053c03a5c1c3,
			128'h1cc22c053c03a331};
		tn = '{3, 4, 10, 6, 9, 7, 9, 9, 9, 12, 7, 9, 8};
		te = '{8'h30, 8'h10, 8'hc0, 8'h10, 8'h40, 8'h40, 8'h40, 8'h40, 8'h40, 8'h20, 8'h80,
			8'ha0, 8'ha0};
		dp = '{64'h1e1e, 64'ha6c100a6c100, 64'h8b008b00, 64'h8d00038d0006};
		dn = '{1, 3, 2, 3};
		dc = '{4, 6, 6, 8};
		// Flag results of the arithmetic, clear and move forms.
		for (k = 0; k < 13; k = k + 1) begin
			run(tp[k], tn[k], 16'(tn[k]), 80);
			if (k < 3) chkv(flags_q, te[k], "flags");
			else if (k < 6) chkv(flags_q, te[k], "flags");
			else if (k < 9) chkv(flags_q, te[k], "flags");
			else chkv(flags_q, te[k], "flags");
		end
		// Every condition code on both branch forms, flags C and S set.
		for (k = 0; k < 16; k = k + 1) begin
			e = (k < 8) ? k[0] ^ (k != 0 && k != 4 && k != 6) ^ k[0] : !(k != 8 && k != 12 && k != 14);
			run({48'h1c022c03a212, k[3:0], 4'hb, 8'h03}, 8, 16'h000b, 60);
			chkb(hit, e, "relative branch");
			run({48'h1c022c03a212, k[3:0], 4'hd, 16'h000b}, 9, 16'h000b, 60);
			chkb(hit, e, "direct branch");
		end
		// Cycle cost of one instruction as the difference of one and two copies.
		for (k = 0; k < 4; k = k + 1) begin
			run(128'(dp[k] >> (8 * dn[k])), dn[k], 16'(dn[k]), 80);
			c1 = cyc;
			run(128'(dp[k]), 2 * dn[k], 16'(2 * dn[k]), 80);
			chkv(16'(cyc - c1), 16'(dc[k]), "cycles");
		end
		// Register-pair jump, unknown opcode, service return.
		run(128'h1c002c0c30c1, 6, 16'h000c, 80);
		chkb(hit, 1'b1, "pair jump");
		chkb(illegal_q, 1'b0, "legal opcode");
		// A run of unknown two-byte opcodes, looked at while it still executes.
		run({16{8'hff}}, 16, 16'h00f0, 4);
		chkb(illegal_q, 1'b1, "unknown opcode");
		run(128'h1cc019001c0019011c201902bf, 13, 16'h0020, 120);
		chkb(hit, 1'b1, "return target");
		chkv(flags_q, 8'hc0, "restored flags");
		chkv(systemModeReg_q, 8'h08, "return enables");
		chkv(sp_q, 8'h03, "stack pointer");
		// Enable, disable, then a request while disabled and idle.
		run(128'h9f, 1, 16'h0001, 40);
		chkv(systemModeReg_q, 8'h08, "enable");
		run(128'h9f8f, 2, 16'h0002, 40);
		chkv(systemModeReg_q, 8'h00, "disable");
		run(128'h8f6f9f, 3, 16'h0003, 40);
		chkb(idle_q, 1'b1, "idle");
		chkb(busy_q, 1'b0, "busy while idle");
		irqIn = 8'h02;
		@(posedge clk);
		#1 irqIn = 8'h00;
		chkv(pending_q, 8'h02, "pending");
		hit = 1'b0;
		for (k = 0; k < 60; k = k + 1) begin
			@(posedge clk);
			#1 if (pc_q === 16'h0000) hit = 1'b1;
		end
		chkb(hit, 1'b1, "service after enable");
		results;
	end
	// Watchdog, well past the expected length of the tests.
	initial begin
		#500000;
		n_fail = n_fail + 1;
		$display("mismatch at %0t: run did not finish", $time);
		results;
	end
endmodule // tb
